// *** design/atc_top.sv ***
/*
 Audio input configuration and I2S/TDM format conversion.
 Assumes BCLK is the TDM bit clock, that the I2S source shifts on the
 quarter-rate clock driven out here, and that TDM input shares BCLK.
*/
// What this block does
// - TDM enable merges parallel lines into one stream
// - Source select off stops transmit and downstream words, not receive; resets on
// - TDM-to-parallel splits serial line onto four lines
// - Polarity bit: 0 sync high, 1 low
// - Frame sync pulse marks first sample
// - Polarity and delay govern both conversion directions
// - Delay bit: data starts zero or one bit late
// - Width code: half frame, one slot, one bit
// - TDM enable resets off; plain I2S forwarded
`timescale 1ns/1ps
module atc_top
	import atc_pkg::*;
(
	// System clock and register port
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WE,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// Audio bit clock
	input wire logic BCLK,
	// Parallel I2S lines
	output logic I2S_SCK_O,
	output logic I2S_WS_O,
	input wire logic [`ATC_LINES-1:0] I2S_DIN,
	output logic [`ATC_LINES-1:0] I2S_DOUT,
	// TDM serial line
	output logic SERIAL_AUDIO_DATA_LINE_O,
	output logic TDM_FS_O,
	input wire logic SERIAL_AUDIO_DATA_LINE_I,
	input wire logic TDM_FS_I,
	// Downstream words
	output logic DS_VALID,
	input wire logic DS_READY,
	output atc_word_t DS_WORD
);
	localparam int FRAME = `ATC_SLOTS * `ATC_SLOT_W;
	localparam int LW = 2 * `ATC_SLOT_W;
	localparam int CW = $clog2(FRAME);
	localparam logic [CW-1:0] LAST_C = CW'(FRAME - 1);
	localparam logic [CW-1:0] HALF_C = CW'(FRAME / 2);
	localparam logic [CW-1:0] SLOT_C = CW'(`ATC_SLOT_W);
	localparam logic [1:0] QLAST_C = 2'(`ATC_QDIV - 1);
	localparam logic [7:0] RB_C = `ATC_RST_BRIDGE;
	localparam logic [7:0] RR_C = `ATC_RST_RECV;
	localparam logic [7:0] RF_C = `ATC_RST_FMT;
	// Crossing stages start at the register reset values so audio stays on from reset
	localparam atc_cfg_t CFG_RST_C = '{tdm_en: RB_C[`ATC_BIT_TDM], src_en: RB_C[`ATC_BIT_SRC],
		t2p: RR_C[`ATC_BIT_T2P], pol: RF_C[`ATC_BIT_POL], dly: RF_C[`ATC_BIT_DLY],
		fsw: RF_C[`ATC_FSW_HI:`ATC_FSW_LO]};

	function automatic logic fs_active(input logic [CW-1:0] c, input logic [1:0] w);
		if (w == `ATC_FSW_HALF) begin
			return c < HALF_C;
		end else if (w == `ATC_FSW_SLOT) begin
			return c < SLOT_C;
		end else begin
			return c == '0;
		end
	endfunction

	// ============================================================
	// Registers, system clock domain
	logic [7:0] bridge_q, recv_q, fmt_q, rdata_q;
	logic [2:0] run_s_q;
	logic run_stat_q;
	atc_cfg_t cfg_c;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			bridge_q <= `ATC_RST_BRIDGE;
			recv_q <= `ATC_RST_RECV;
			fmt_q <= `ATC_RST_FMT;
		end else if (REG_WE) begin
			if (REG_ADDR == `ATC_ADDR_BRIDGE) begin
				bridge_q <= REG_WDATA & `ATC_MASK_BRIDGE;
			end else if (REG_ADDR == `ATC_ADDR_RECV) begin
				recv_q <= REG_WDATA & `ATC_MASK_RECV;
			end else if (REG_ADDR == `ATC_ADDR_FMT) begin
				fmt_q <= REG_WDATA & `ATC_MASK_FMT;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_q <= 8'h00;
		end else if (REG_ADDR == `ATC_ADDR_BRIDGE) begin
			rdata_q <= bridge_q;
		end else if (REG_ADDR == `ATC_ADDR_RECV) begin
			rdata_q <= recv_q;
		end else if (REG_ADDR == `ATC_ADDR_FMT) begin
			rdata_q <= fmt_q;
		end else if (REG_ADDR == `ATC_ADDR_STAT) begin
			rdata_q <= {7'h00, run_stat_q};
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign REG_RDATA = rdata_q;

	// Receive-frame status back from the bit clock; taken once two stages agree
	logic rx_run_q;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			run_s_q <= 3'h0;
			run_stat_q <= 1'b0;
		end else begin
			run_s_q <= {run_s_q[1:0], rx_run_q};
			if (run_s_q[1] == run_s_q[2]) begin
				run_stat_q <= run_s_q[2];
			end
		end
	end

	always_comb begin
		cfg_c.tdm_en = bridge_q[`ATC_BIT_TDM];
		cfg_c.src_en = bridge_q[`ATC_BIT_SRC];
		cfg_c.t2p = recv_q[`ATC_BIT_T2P];
		cfg_c.pol = fmt_q[`ATC_BIT_POL];
		cfg_c.dly = fmt_q[`ATC_BIT_DLY];
		cfg_c.fsw = fmt_q[`ATC_FSW_HI:`ATC_FSW_LO];
	end

	// ============================================================
	// Bit clock domain: reset release and configuration crossing
	logic [1:0] brst_q;
	logic brst_b;
	atc_cfg_t cs1_q, cs2_q, cs3_q, cfg_q;
	logic [CW-1:0] cnt_q;

	always_ff @(posedge BCLK or negedge RST_B) begin
		if (!RST_B) begin
			brst_q <= 2'h0;
		end else begin
			brst_q <= {brst_q[0], 1'b1};
		end
	end
	assign brst_b = brst_q[1];

	// Per-bit agreement holds each bit until its last two stages match
	always_ff @(posedge BCLK or negedge brst_b) begin
		if (!brst_b) begin
			cs1_q <= CFG_RST_C;
			cs2_q <= CFG_RST_C;
			cs3_q <= CFG_RST_C;
			cfg_q <= CFG_RST_C;
		end else begin
			cs1_q <= cfg_c;
			cs2_q <= cs1_q;
			cs3_q <= cs2_q;
			cfg_q <= atc_cfg_t'((cfg_q & (cs2_q ^ cs3_q)) | (cs3_q & ~(cs2_q ^ cs3_q)));
		end
	end

	always_ff @(posedge BCLK or negedge brst_b) begin
		if (!brst_b) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// ============================================================
	// Parallel capture and TDM transmit
	logic [LW-1:0] line_sh_q [`ATC_LINES];
	logic [FRAME-1:0] cap_q, tx_sh_q;
	logic sck_q, ws_q, sd_q, fs_q;
	logic tx_on;
	assign tx_on = cfg_q.src_en && cfg_q.tdm_en;

	always_ff @(posedge BCLK or negedge brst_b) begin
		if (!brst_b) begin
			for (int i = 0; i < `ATC_LINES; i++) begin
				line_sh_q[i] <= '0;
			end
			cap_q <= '0;
		end else if (cnt_q[1:0] == QLAST_C) begin
			for (int i = 0; i < `ATC_LINES; i++) begin
				line_sh_q[i] <= {line_sh_q[i][LW-2:0], I2S_DIN[i]};
				if (cnt_q == LAST_C) begin
					cap_q[FRAME-1-i*LW -: LW] <= {line_sh_q[i][LW-2:0], I2S_DIN[i]};
				end
			end
		end
	end

	always_ff @(posedge BCLK or negedge brst_b) begin
		if (!brst_b) begin
			sck_q <= 1'b0;
			ws_q <= 1'b0;
		end else begin
			sck_q <= cnt_q[1];
			ws_q <= cnt_q >= HALF_C;
		end
	end

	always_ff @(posedge BCLK or negedge brst_b) begin
		if (!brst_b) begin
			sd_q <= 1'b0;
			fs_q <= 1'b0;
			tx_sh_q <= '0;
		end else if (tx_on) begin
			if (cnt_q == CW'(cfg_q.dly)) begin
				sd_q <= cap_q[FRAME-1];
				tx_sh_q <= {cap_q[FRAME-2:0], 1'b0};
			end else begin
				sd_q <= tx_sh_q[FRAME-1];
				tx_sh_q <= {tx_sh_q[FRAME-2:0], 1'b0};
			end
			fs_q <= fs_active(cnt_q, cfg_q.fsw) ^ cfg_q.pol;
		end else if (cfg_q.src_en) begin
			sd_q <= I2S_DIN[0];
			fs_q <= ws_q;
		end else begin
			sd_q <= 1'b0;
			fs_q <= cfg_q.pol;
		end
	end

	// ============================================================
	// TDM receive and split onto four lines
	logic fsa_q, rx_start, rx_last;
	logic [CW:0] rx_pos_q;
	logic [FRAME-1:0] rx_sh_q, rx_out_q;
	logic [`ATC_LINES-1:0] dout_q;
	assign rx_start = cfg_q.t2p && (TDM_FS_I ^ cfg_q.pol) && !fsa_q;
	assign rx_last = rx_run_q && rx_pos_q == (CW+1)'(FRAME - 1);

	always_ff @(posedge BCLK or negedge brst_b) begin
		if (!brst_b) begin
			fsa_q <= 1'b0;
			rx_run_q <= 1'b0;
			rx_pos_q <= '0;
			rx_sh_q <= '0;
			rx_out_q <= '0;
		end else begin
			fsa_q <= TDM_FS_I ^ cfg_q.pol;
			if (rx_run_q || (rx_start && !cfg_q.dly)) begin
				rx_sh_q <= {rx_sh_q[FRAME-2:0], SERIAL_AUDIO_DATA_LINE_I};
			end
			if (rx_last) begin
				rx_out_q <= {rx_sh_q[FRAME-2:0], SERIAL_AUDIO_DATA_LINE_I};
			end
			if (!cfg_q.t2p) begin
				rx_run_q <= 1'b0;
			end else if (rx_start) begin
				rx_run_q <= 1'b1;
				rx_pos_q <= cfg_q.dly ? '0 : (CW+1)'(1);
			end else begin
				rx_run_q <= rx_run_q && !rx_last;
				rx_pos_q <= rx_pos_q + 1'b1;
			end
		end
	end

	always_ff @(posedge BCLK or negedge brst_b) begin
		if (!brst_b) begin
			dout_q <= '0;
		end else begin
			for (int i = 0; i < `ATC_LINES; i++) begin
				dout_q[i] <= cfg_q.t2p && rx_out_q[FRAME-1-i*LW-int'(cnt_q[CW-1:2])];
			end
		end
	end

	// ============================================================
	// Downstream sequencer and two-entry buffer
	atc_state_t st_q;
	logic [FRAME-1:0] ds_frame_q;
	logic [2:0] idx_q;
	logic tag_q, push, pop, out_v_q, skid_v_q;
	atc_word_t in_w, out_q, skid_q;
	assign push = st_q == ST_SEND && !skid_v_q;
	assign pop = out_v_q && DS_READY;
	assign in_w = '{tdm: tag_q, slot: idx_q,
		data: ds_frame_q[FRAME-1-int'(idx_q)*`ATC_SLOT_W -: `ATC_SLOT_W]};

	// A frame still draining when the next completes is skipped, not merged
	always_ff @(posedge BCLK or negedge brst_b) begin
		if (!brst_b) begin
			st_q <= ST_IDLE;
			ds_frame_q <= '0;
			idx_q <= 3'h0;
			tag_q <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (cnt_q == '0 && cfg_q.src_en) begin
						ds_frame_q <= cap_q;
						tag_q <= cfg_q.tdm_en;
						idx_q <= 3'h0;
						st_q <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (push) begin
						idx_q <= idx_q + 1'b1;
						if (idx_q == 3'(`ATC_SLOTS - 1)) begin
							st_q <= ST_IDLE;
						end
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge BCLK or negedge brst_b) begin
		if (!brst_b) begin
			out_v_q <= 1'b0;
			skid_v_q <= 1'b0;
			out_q <= '0;
			skid_q <= '0;
		end else if (!out_v_q || pop) begin
			out_v_q <= skid_v_q || push;
			out_q <= skid_v_q ? skid_q : in_w;
			skid_v_q <= 1'b0;
		end else if (push) begin
			skid_q <= in_w;
			skid_v_q <= 1'b1;
		end
	end

	assign I2S_SCK_O = sck_q;
	assign I2S_WS_O = ws_q;
	assign I2S_DOUT = dout_q;
	assign SERIAL_AUDIO_DATA_LINE_O = sd_q;
	assign TDM_FS_O = fs_q;
	assign DS_VALID = out_v_q;
	assign DS_WORD = out_q;

	// ============================================================
	// Checks
	sequence s_stall;
		DS_VALID && !DS_READY;
	endsequence
	sequence s_fs_bit;
		TDM_FS_O == !cfg_q.pol ##1 TDM_FS_O == cfg_q.pol;
	endsequence
	property p_hold;
		@(posedge BCLK) disable iff (!brst_b) s_stall |=> DS_VALID && $stable(DS_WORD);
	endproperty
	a_hold: assert property (p_hold) else $error("Stalled word changed");
	property p_src_off;
		@(posedge BCLK) disable iff (!brst_b)
			(!cfg_q.src_en && !DS_VALID && st_q == ST_IDLE) |=> !DS_VALID;
	endproperty
	a_src_off: assert property (p_src_off) else $error("Word sent while disabled");
	property p_t2p_off;
		@(posedge BCLK) disable iff (!brst_b) !cfg_q.t2p |=> I2S_DOUT == '0;
	endproperty
	a_t2p_off: assert property (p_t2p_off) else $error("Split lines active when off");
	property p_pol;
		@(posedge BCLK) disable iff (!brst_b)
			(tx_on && cnt_q == '0 && $stable(cfg_q)) |=> TDM_FS_O == !cfg_q.pol;
	endproperty
	a_pol: assert property (p_pol) else $error("Frame sync level wrong");
	property p_start;
		@(posedge BCLK) disable iff (!brst_b)
			rx_start |=> rx_run_q && rx_pos_q == (cfg_q.dly ? '0 : (CW+1)'(1));
	endproperty
	a_start: assert property (p_start) else $error("Receive frame not started");
	property p_rxpol;
		@(posedge BCLK) disable iff (!brst_b)
			(cfg_q.t2p && $rose(TDM_FS_I ^ cfg_q.pol) && $stable(cfg_q)) |-> rx_start;
	endproperty
	a_rxpol: assert property (p_rxpol) else $error("Receive sync edge missed");
	property p_dly;
		@(posedge BCLK) disable iff (!brst_b)
			(tx_on && cnt_q == CW'(cfg_q.dly)) |=> SERIAL_AUDIO_DATA_LINE_O == $past(cap_q[FRAME-1]);
	endproperty
	a_dly: assert property (p_dly) else $error("First slot bit misplaced");
	property p_width1;
		@(posedge BCLK) disable iff (!brst_b)
			(tx_on && cfg_q.fsw[1] && cnt_q == '0 && $stable(cfg_q)) |=> s_fs_bit;
	endproperty
	a_width1: assert property (p_width1) else $error("Sync not one bit wide");
	property p_plain;
		@(posedge BCLK) disable iff (!brst_b)
			(cfg_q.src_en && !cfg_q.tdm_en) |=> SERIAL_AUDIO_DATA_LINE_O == $past(I2S_DIN[0]);
	endproperty
	a_plain: assert property (p_plain) else $error("Plain audio not forwarded");
	property p_order;
		@(posedge BCLK) disable iff (!brst_b)
			(push && idx_q != 3'(`ATC_SLOTS - 1)) |=> idx_q == $past(idx_q) + 3'h1;
	endproperty
	a_order: assert property (p_order) else $error("Slots out of order");
endmodule

// *** design/atc_regs.svh ***
/*
 Register offsets, field positions, reset values and framing counts for the
 audio conversion block. Assumes byte-wide registers on the serial control bus.
*/
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH
// ============================================================
// Register offsets
`define ATC_ADDR_BRIDGE 8'h54
`define ATC_ADDR_RECV 8'h55
`define ATC_ADDR_FMT 8'h57
`define ATC_ADDR_STAT 8'h58
// ============================================================
// Reset values and writable masks
`define ATC_RST_BRIDGE 8'h02
`define ATC_RST_RECV 8'h00
`define ATC_RST_FMT 8'h02
`define ATC_MASK_BRIDGE 8'h06
`define ATC_MASK_RECV 8'h80
`define ATC_MASK_FMT 8'h0f
// ============================================================
// Field positions
`define ATC_BIT_TDM 2
`define ATC_BIT_SRC 1
`define ATC_BIT_T2P 7
`define ATC_BIT_POL 3
`define ATC_BIT_DLY 2
`define ATC_FSW_HI 1
`define ATC_FSW_LO 0
`define ATC_BIT_RUN 0
// ============================================================
// Frame sync width codes and framing
`define ATC_FSW_HALF 2'b00
`define ATC_FSW_SLOT 2'b01
`define ATC_SLOT_W 16
`define ATC_LINES 4
`define ATC_SLOTS 8
`define ATC_QDIV 4
`endif

// *** design/atc_pkg.sv ***
/*
 Types shared by the audio conversion block.
 Assumes atc_regs.svh is on the include path.
*/
`include "atc_regs.svh"
package atc_pkg;
	// ============================================================
	// Configuration carried into the bit clock domain
	typedef struct packed {
		logic tdm_en;
		logic src_en;
		logic t2p;
		logic pol;
		logic dly;
		logic [1:0] fsw;
	} atc_cfg_t;
	// ============================================================
	// One audio word toward the downstream framing
	typedef struct packed {
		logic tdm;
		logic [2:0] slot;
		logic [`ATC_SLOT_W-1:0] data;
	} atc_word_t;
	// ============================================================
	// Downstream word sequencer
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} atc_state_t;
endpackage

// *** tb/atc_audio_src.sv ***
/*
 Model of the external audio processor: an I2S source shifting on the bit
 clock that the device drives, and a TDM source on the audio bit clock.
 Assumes the device drives sck and ws and samples on their rising edges.
*/
`timescale 1ns/1ps
module atc_audio_src (
	// Clocks from the device side
	input wire logic bclk,
	input wire logic sck,
	input wire logic ws,
	// TDM source control
	input wire logic t_en,
	input wire logic t_pol,
	input wire logic t_dly,
	// Audio lines
	output logic [3:0] din,
	output logic sd,
	output logic fs
);
	// ============================================================
	// Sample patterns
	function automatic logic [15:0] smp(input int l, input int c);
		return 16'(16'h9c35 + l * 16'h1111 + c * 16'h0707);
	endfunction
	logic wsp = 1'b0;
	logic [15:0] w;
	int k = 0;
	int j = 0;
	logic [127:0] fr;
	initial begin
		din = 4'h0;
		sd = 1'b0;
		fs = 1'b0;
		for (int s = 0; s < 8; s++) begin
			fr[127 - 16 * s -: 16] = ~smp(s / 2, s % 2);
		end
	end
	// ============================================================
	// I2S source: MSB goes out at the word select change
	// Word select moves in the same step as sck; look once it has settled
	always @(negedge sck) begin
		#1;
		k = (ws != wsp) ? 0 : k + 1;
		wsp = ws;
		for (int l = 0; l < 4; l++) begin
			w = smp(l, ws);
			din[l] <= w[15 - (k & 15)];
		end
	end
	// ============================================================
	// TDM source: free running, idle line toggles so no stale bit looks valid
	always @(negedge bclk) begin
		j = (j + 1) & 127;
		fs <= ((j == 0) && t_en) ^ t_pol;
		sd <= t_en ? fr[127 - ((j - t_dly) & 127)] : ~sd;
	end
endmodule

// *** tb/test_tdm_i2s_audio_conversion.sv ***
/*
 Self-checking bench for the audio conversion block.
 Assumes the design package is compiled first; BCLK runs unrelated to CLK.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_tdm_i2s_audio_conversion
	import atc_pkg::*;
;
	logic CLK = 1'b0;
	logic BCLK = 1'b0;
	logic RST_B, REG_WE, DS_READY, DS_VALID, I2S_SCK_O, I2S_WS_O;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
	logic [3:0] I2S_DIN, I2S_DOUT;
	logic SD_O, FS_O, SD_I, FS_I, t_en, t_pol, t_dly, wsp;
	atc_word_t DS_WORD;
	logic [15:0] sh [4];
	logic [15:0] rx [8];
	int bad_count = 0;
	int checked = 0;
	logic [24:0] rows [11] = '{25'h0_54_00_02, 25'h0_55_00_00, 25'h0_57_00_02,
		25'h0_56_00_00, 25'h1_57_ff_0f, 25'h1_54_ff_06, 25'h1_55_ff_80,
		25'h1_60_ff_00, 25'h1_57_00_00, 25'h1_54_02_02, 25'h1_55_00_00};
	atc_top dut (.CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WE(REG_WE),
		.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .BCLK(BCLK),
		.I2S_SCK_O(I2S_SCK_O), .I2S_WS_O(I2S_WS_O), .I2S_DIN(I2S_DIN),
		.I2S_DOUT(I2S_DOUT), .SERIAL_AUDIO_DATA_LINE_O(SD_O), .TDM_FS_O(FS_O),
		.SERIAL_AUDIO_DATA_LINE_I(SD_I), .TDM_FS_I(FS_I), .DS_VALID(DS_VALID),
		.DS_READY(DS_READY), .DS_WORD(DS_WORD));
	atc_audio_src src (.bclk(BCLK), .sck(I2S_SCK_O), .ws(I2S_WS_O), .t_en(t_en),
		.t_pol(t_pol), .t_dly(t_dly), .din(I2S_DIN), .sd(SD_I), .fs(FS_I));
	initial begin
		forever #12.5 CLK = ~CLK;
	end
	initial begin
		#7;
		forever #24 BCLK = ~BCLK;
	end
	initial begin
		#1000000;
		bad_count++;
		conclude;
	end
	function automatic logic [15:0] smp(input int l, input int c);
		return 16'(16'h9c35 + l * 16'h1111 + c * 16'h0707);
	endfunction
	// ============================================================
	// I2S receiver on the split lines
	always @(posedge I2S_SCK_O) begin
		for (int l = 0; l < 4; l++) begin
			if (I2S_WS_O != wsp) rx[2 * l + wsp] = sh[l];
			sh[l] = {sh[l][14:0], I2S_DOUT[l]};
		end
		wsp = I2S_WS_O;
	end
	task conclude;
		$display("checks=%0d mismatches=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge CLK);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WE = 1'b1;
		@(negedge CLK);
		REG_WE = 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge CLK);
		REG_ADDR = a;
		@(negedge CLK);
		d = REG_RDATA;
	endtask
	task bwait(input int n);
		repeat (n) @(negedge BCLK);
	endtask
	// Sync width and slot order of the generated stream
	task tdm_chk(input logic p, input logic d, input int wd);
		logic [127:0] f;
		logic a, b;
		int n, k;
		n = 0;
		a = 1'b1;
		do begin
			b = a;
			@(negedge BCLK);
			a = FS_O ^ p;
			n++;
		end while (n < 400 && !(a && !b));
		if (n >= 400) begin
			bad_count++;
			conclude;
		end
		k = 0;
		for (int j = 0; j < 128 + d; j++) begin
			if (j >= d) f = {f[126:0], SD_O};
			if (j < 128 && (FS_O ^ p)) k++;
			@(negedge BCLK);
		end
		`CHK(k, wd)
		for (int s = 0; s < 8; s++) `CHK(f[127 - 16 * s -: 16], smp(s / 2, s % 2))
	endtask
	// Downstream words with a long stall in mid-frame
	task ds_chk(input logic t);
		int n, s, st;
		n = 0;
		s = 0;
		st = 0;
		while (s < 8 && n < 600) begin
			@(negedge BCLK);
			DS_READY = !(s == 3 && st < 10);
			if (s == 3) st++;
			n++;
			// Settled outputs plus this ready decide the transfer at the next rising edge
			if (DS_VALID && DS_READY && (s > 0 || DS_WORD.slot === 3'h0)) begin
				`CHK(DS_WORD, {t, s[2:0], smp(s / 2, s % 2)})
				s++;
			end
		end
		DS_READY = 1'b1;
		if (s < 8) begin
			bad_count++;
			conclude;
		end
	endtask
	initial begin
		logic [7:0] d;
		REG_ADDR = 8'h00;
		REG_WE = 1'b0;
		REG_WDATA = 8'h00;
		DS_READY = 1'b1;
		RST_B = 1'b0;
		t_en = 1'b0;
		t_pol = 1'b0;
		t_dly = 1'b0;
		wsp = 1'b0;
		repeat (12) @(negedge CLK);
		RST_B = 1'b1;
		for (int i = 0; i < 11; i++) begin
			if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], d);
			`CHK(d, rows[i][7:0])
		end
		bwait(400);
		ds_chk(1'b0);
		for (int i = 0; i < 4; i++) begin
			wr(8'h57, {4'h0, i[0], i[1], i[1:0]});
			wr(8'h54, 8'h06);
			bwait(300);
			tdm_chk(i[0], i[1], (i == 0) ? 64 : (i == 1) ? 16 : 1);
		end
		ds_chk(1'b1);
		wr(8'h54, 8'h04);
		bwait(300);
		for (int n = 0; n < 300; n++) begin
			@(negedge BCLK);
			`CHK({DS_VALID, SD_O, FS_O}, 3'b001)
		end
		t_pol = 1'b1;
		t_dly = 1'b1;
		t_en = 1'b1;
		wr(8'h57, 8'h0e);
		wr(8'h55, 8'h80);
		bwait(600);
		for (int s = 0; s < 8; s++) `CHK(rx[s], ~smp(s / 2, s % 2))
		wr(8'h55, 8'h00);
		bwait(300);
		`CHK(I2S_DOUT, 4'h0)
		conclude;
	end
endmodule
